/* hdl/rst_ctl_defs.svh */
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit avalon word addressing, one register per word
// Notes: included by the two design files, not by the package
`ifndef RST_CTL_DEFS_SVH
`define RST_CTL_DEFS_SVH

`define ADDR_W 4
// register word addresses
`define ETH_CONTROL_ONE_ADDR 4'h0
`define PHY_CONTROL_ONE_ADDR 4'h1
`define RX_STATUS_ADDR 4'h2
// eth_control_one fields
`define RECEIVE_ENABLE_POS 2
`define RECEIVE_RESET_POS 6
// phy_control_one fields
`define PHY_SOFT_RESET_POS 15
`define PHY_LOOPBACK_POS 14
`define PHY_POWER_DOWN_POS 11
`define PHY_RSVD_HI_POS 10
`define PHY_DUPLEX_POS 8
`define PHY_RSVD_LO_POS 7
// writable bits of phy_control_one; everything else reads zero
`define PHY_CTRL_MASK 16'hc900
// phy reset delay, in nanoseconds, and derived cycle count at 40 ns
`define CLK_PERIOD_NS 40
`define PHY_RESET_TIME_NS 10000
`define PHY_RESET_CYCLES ((`PHY_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHY_CNT_W 16
// answer for unmapped reads
`define UNMAPPED_DATA 32'h0000_0000

`endif

/* hdl/rst_ctl_pkg.sv */
// Purpose: shared types for the receive and phy reset control block
// Assumes: rst_ctl_defs.svh holds all numbers
// Notes: only types live here
package rst_ctl_pkg;
  typedef enum logic [1:0] {
    PHY_IDLE,
    PHY_IN_RESET
  } phy_state_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ANSWER
  } bus_state_t;
endpackage

/* hdl/phy_ctrl_if.sv */
// Purpose: carries phy control register values to the phy control register module
// Assumes: single clock domain
// Notes: the main module drives writes, the register module returns state
`timescale 1ns/1ps
interface phy_ctrl_if;
  logic wr_en;
  logic [15:0] wr_data;
  logic soft_reset_req;
  logic [15:0] rd_data;
  logic in_reset;
  logic loopback;
  logic power_down;
  logic full_duplex;

  modport ctl (
    output wr_en,
    output wr_data,
    output soft_reset_req,
    input rd_data,
    input in_reset,
    input loopback,
    input power_down,
    input full_duplex
  );
  modport regs (
    input wr_en,
    input wr_data,
    input soft_reset_req,
    output rd_data,
    output in_reset,
    output loopback,
    output power_down,
    output full_duplex
  );
endinterface // phy_ctrl_if

/* hdl/phy_control_regs.sv */
// Purpose: phy control register with self-clearing software reset
// Assumes: synchronous reset, strap level stable at reset release
// Notes: the reset delay is a parameter so simulation may shorten it
`timescale 1ns/1ps
`include "rst_ctl_defs.svh"
module phy_control_regs
  import rst_ctl_pkg::*;
#(
  parameter int unsigned PHY_RESET_CYCLES = `PHY_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic second_led_pin,
  phy_ctrl_if.regs pc
);
  localparam logic [`PHY_CNT_W-1:0] CNT_LAST = `PHY_CNT_W'(PHY_RESET_CYCLES - 1);

  phy_state_t state_reg;
  logic [`PHY_CNT_W-1:0] cnt_reg;
  logic loopback_reg;
  logic power_down_reg;
  logic duplex_reg;
  logic strap_take_reg;
  logic reset_start;

  // a write with bit 15 high, or a system reset request, starts the phy reset
  assign reset_start = pc.soft_reset_req ||
    (pc.wr_en && pc.wr_data[`PHY_SOFT_RESET_POS]);

  // reset sequencer; bit stays one until the count expires
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= PHY_IDLE;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        PHY_IDLE: begin
          cnt_reg <= '0;
          if (reset_start) begin
            state_reg <= PHY_IN_RESET; // [RULE7]
          end
        end
        PHY_IN_RESET: begin
          if (cnt_reg == CNT_LAST) begin
            state_reg <= PHY_IDLE; // [RULE8] [RULE16]
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1; // [RULE16]
          end
        end
        default: begin
          state_reg <= PHY_IDLE;
          cnt_reg <= '0;
        end
      endcase
    end
  end

  // duplex strap is caught on the first clock after reset release
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_take_reg <= 1'b1;
    end else begin
      strap_take_reg <= 1'b0;
    end
  end

  // control bits; a phy reset restores defaults, duplex from the led strap
  always_ff @(posedge clk) begin
    if (srst) begin
      loopback_reg <= 1'b0;
      power_down_reg <= 1'b0;
      duplex_reg <= 1'b0;
    end else if (strap_take_reg || reset_start) begin
      loopback_reg <= 1'b0; // [RULE7]
      power_down_reg <= 1'b0;
      duplex_reg <= second_led_pin; // [RULE13]
    end else if (pc.wr_en && state_reg == PHY_IDLE) begin
      loopback_reg <= pc.wr_data[`PHY_LOOPBACK_POS]; // [RULE10]
      power_down_reg <= pc.wr_data[`PHY_POWER_DOWN_POS]; // [RULE11]
      duplex_reg <= pc.wr_data[`PHY_DUPLEX_POS]; // [RULE12]
    end
  end

  // read view, no extra stage so the bus register sees current state
  always_comb begin
    pc.rd_data = 16'h0000; // [RULE15]
    pc.rd_data[`PHY_SOFT_RESET_POS] = (state_reg == PHY_IN_RESET); // [RULE8]
    pc.rd_data[`PHY_LOOPBACK_POS] = loopback_reg;
    pc.rd_data[`PHY_POWER_DOWN_POS] = power_down_reg;
    pc.rd_data[`PHY_DUPLEX_POS] = duplex_reg;
  end

  assign pc.in_reset = (state_reg == PHY_IN_RESET);
  assign pc.loopback = loopback_reg;
  assign pc.power_down = power_down_reg;
  assign pc.full_duplex = duplex_reg;
endmodule // phy_control_regs

/* hdl/rx_and_phy_reset_control.sv */
// Purpose: receive-only reset and phy software reset control with avalon registers
// Assumes: one 25 MHz clock, synchronous active-high reset, master holds requests
// Notes: register answers come one cycle after the request is seen
`timescale 1ns/1ps
`include "rst_ctl_defs.svh"

// Overview of operation
// RULE1: setting receive reset holds only the receive logic in reset.
// RULE2: setting receive reset while reception enabled clears the enable bit.
// RULE3: a packet in progress is aborted at once on receive reset.
// RULE4: receive reset leaves all other registers and blocks untouched.
// RULE5: system reset also performs the receive-only reset action.
// RULE6: host clears receive reset itself to resume reception.
// RULE7: writing one to phy bit 15 restores all phy registers to defaults.
// RULE8: phy reset bit reads one until the internal delay ends.
// RULE9: host polls the phy reset bit before using the phy.
// RULE10: loopback bit 14 returns transmit data and disables twisted pair.
// RULE11: power-down bit 11 shuts the phy down.
// RULE12: duplex bit 8 selects full duplex when one, half when zero.
// RULE13: duplex reset value follows the led strap on the second led pin.
// RULE14: host writes zero to reserved phy bits 10 and 7.
// RULE15: unimplemented phy bits 13-12, 9 and 6-0 read zero.
// RULE16: phy reset delay is a parameterised cycle count.
module rx_and_phy_reset_control
  import rst_ctl_pkg::*;
#(
  parameter int unsigned PHY_RESET_CYCLES = `PHY_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic system_reset_req,
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_packet_active,
  input wire logic second_led_pin,
  output logic rx_logic_reset,
  output logic rx_abort,
  output logic rx_enable,
  output logic phy_in_reset,
  output logic phy_loopback,
  output logic twisted_pair_enable,
  output logic phy_power_down,
  output logic phy_full_duplex
);
  phy_ctrl_if pc ();

  bus_state_t bus_state_reg;
  logic receive_enable_bit_reg;
  logic receive_reset_bit_reg;
  logic rx_abort_reg;
  logic rx_aborted_seen_reg;
  logic [31:0] rdata_reg;
  logic req;
  logic wr_take;
  logic rd_take;
  logic low_lane;
  logic high_lane;
  logic ecs_wr;
  logic phy_wr;
  logic rx_reset_rise;
  logic sys_rx_reset;

  // address compare shared by read and write paths
  function automatic logic addr_hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] b);
    addr_hit = (a == b);
  endfunction

  // status word for the receive path
  function automatic logic [31:0] rx_status_word(input logic rst_b, input logic act,
                                                input logic ab);
    rx_status_word = {29'h0000_0000, ab, act, rst_b};
  endfunction

  // bus request decode; a request is answered one cycle after it is seen
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && (bus_state_reg != BUS_ANSWER);
  assign wr_take = avs_write && (bus_state_reg == BUS_ANSWER);
  assign rd_take = avs_read && (bus_state_reg == BUS_ANSWER);
  assign low_lane = avs_byteenable[0];
  assign high_lane = avs_byteenable[1];
  assign ecs_wr = wr_take && low_lane && addr_hit(avs_address, `ETH_CONTROL_ONE_ADDR);
  assign phy_wr = wr_take && (low_lane || high_lane) &&
    addr_hit(avs_address, `PHY_CONTROL_ONE_ADDR);

  // system reset request runs the same receive reset action
  assign sys_rx_reset = system_reset_req; // [RULE5]

  // rising edge of receive reset, by write or by system reset
  assign rx_reset_rise = (ecs_wr && avs_writedata[`RECEIVE_RESET_POS] &&
    !receive_reset_bit_reg) || sys_rx_reset;

  // bus handshake state
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (req) begin
            bus_state_reg <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: begin
          bus_state_reg <= BUS_IDLE;
        end
        default: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // receive reset bit: set and cleared by the host, also cleared by a system reset request
  always_ff @(posedge clk) begin
    if (srst) begin
      receive_reset_bit_reg <= 1'b0;
    end else if (sys_rx_reset) begin
      receive_reset_bit_reg <= 1'b0; // [RULE5]
    end else if (ecs_wr) begin
      receive_reset_bit_reg <= avs_writedata[`RECEIVE_RESET_POS]; // [RULE1] [RULE6]
    end
  end

  // receive enable: hardware clears it when receive reset is set
  always_ff @(posedge clk) begin
    if (srst) begin
      receive_enable_bit_reg <= 1'b0;
    end else if (rx_reset_rise) begin
      receive_enable_bit_reg <= 1'b0; // [RULE2]
    end else if (ecs_wr) begin
      receive_enable_bit_reg <= avs_writedata[`RECEIVE_ENABLE_POS];
    end
  end

  // abort pulse for a packet caught in flight
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_abort_reg <= 1'b0;
    end else begin
      rx_abort_reg <= rx_reset_rise && rx_packet_active; // [RULE3]
    end
  end

  // sticky record of an aborted packet, cleared by writing one
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_aborted_seen_reg <= 1'b0;
    end else if (rx_reset_rise && rx_packet_active) begin
      rx_aborted_seen_reg <= 1'b1;
    end else if (wr_take && low_lane && addr_hit(avs_address, `RX_STATUS_ADDR) &&
                 avs_writedata[2]) begin
      rx_aborted_seen_reg <= 1'b0;
    end
  end

  // read data mux; reserved bits and unmapped words read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= `UNMAPPED_DATA;
    end else if (avs_read && bus_state_reg == BUS_IDLE) begin
      if (addr_hit(avs_address, `ETH_CONTROL_ONE_ADDR)) begin
        rdata_reg <= 32'h0000_0000;
        rdata_reg[`RECEIVE_RESET_POS] <= receive_reset_bit_reg;
        rdata_reg[`RECEIVE_ENABLE_POS] <= receive_enable_bit_reg;
      end else if (addr_hit(avs_address, `PHY_CONTROL_ONE_ADDR)) begin
        rdata_reg <= {16'h0000, pc.rd_data}; // [RULE15]
      end else if (addr_hit(avs_address, `RX_STATUS_ADDR)) begin
        rdata_reg <= rx_status_word(receive_reset_bit_reg, rx_packet_active,
                                    rx_aborted_seen_reg);
      end else begin
        rdata_reg <= `UNMAPPED_DATA;
      end
    end
  end

  assign avs_readdata = rdata_reg;

  // phy register block; reserved bits written are dropped by the mask
  assign pc.wr_en = phy_wr;
  assign pc.wr_data = avs_writedata[15:0] & `PHY_CTRL_MASK; // [RULE14]
  assign pc.soft_reset_req = system_reset_req;

  phy_control_regs #(
    .PHY_RESET_CYCLES(PHY_RESET_CYCLES)
  ) u_phy_regs (
    .clk(clk),
    .srst(srst),
    .second_led_pin(second_led_pin),
    .pc(pc)
  );

  // receive logic held only by receive reset; other blocks keep running
  assign rx_logic_reset = receive_reset_bit_reg || sys_rx_reset; // [RULE1] [RULE4]
  assign rx_abort = rx_abort_reg;
  // enable drops in the same cycle as a system reset request too
  assign rx_enable = receive_enable_bit_reg && !rx_logic_reset; // [RULE1]

  // phy controls; only twisted pair enable is gated while the phy is held in reset
  assign phy_in_reset = pc.in_reset; // [RULE9]
  assign phy_loopback = pc.loopback; // [RULE10]
  assign twisted_pair_enable = !pc.loopback && !pc.power_down &&
    !pc.in_reset; // [RULE10] [RULE11]
  assign phy_power_down = pc.power_down; // [RULE11]
  assign phy_full_duplex = pc.full_duplex; // [RULE12]
endmodule // rx_and_phy_reset_control

/* dv/rx_and_phy_reset_control_properties.sv */
// Purpose: port checks of receive and phy reset
// Assumes: one clock, srst sync active high
// Notes: bound to the top module below
`timescale 1ns/1ps
module rst_ctl_checker #(
  parameter int unsigned PHY_RESET_CYCLES = 250
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic system_reset_req,
  input wire logic rx_packet_active,
  input wire logic rx_logic_reset,
  input wire logic rx_abort,
  input wire logic rx_enable,
  input wire logic phy_in_reset,
  input wire logic phy_loopback,
  input wire logic phy_power_down,
  input wire logic twisted_pair_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  int unsigned cnt_reg;
  // length of the current phy reset
  always_ff @(posedge clk) begin
    if (srst || !phy_in_reset) cnt_reg <= 0;
    else cnt_reg <= cnt_reg + 1;
  end
  AST_SYS_RX: assert property (system_reset_req |-> rx_logic_reset)
    else $error("system reset without rx reset");
  AST_RX_EN_OFF: assert property (rx_logic_reset |-> !rx_enable)
    else $error("rx enabled in reset");
  // a write of the reset bit raises reset and abort together
  AST_ABORT_RISE: assert property (
    $rose(rx_logic_reset) && !system_reset_req && $past(rx_packet_active) |-> rx_abort)
    else $error("no abort");
  // a system reset request aborts one cycle after it is seen
  AST_ABORT_SYS: assert property (
    system_reset_req && rx_packet_active |=> rx_abort)
    else $error("no abort on system reset");
  AST_ABORT_CAUSE: assert property (
    rx_abort |-> $past(rx_packet_active) &&
    ($rose(rx_logic_reset) || $past(system_reset_req)))
    else $error("stray abort");
  AST_ABORT_ONE: assert property (rx_abort |=> !rx_abort)
    else $error("abort too long");
  AST_PHY_TIME: assert property ($fell(phy_in_reset) |-> cnt_reg == PHY_RESET_CYCLES)
    else $error("phy reset length");
  AST_PHY_DEF: assert property (phy_in_reset |-> !phy_loopback && !phy_power_down)
    else $error("phy bits kept in reset");
  AST_TP_OFF: assert property (
    twisted_pair_enable == !(phy_loopback || phy_power_down || phy_in_reset))
    else $error("twisted pair state");
  AST_RX_ONLY: assert property (
    $rose(rx_logic_reset) && !system_reset_req |=> $stable(phy_loopback))
    else $error("rx reset touched phy");
  // main scenarios
  cover property (rx_abort);
  cover property ($fell(phy_in_reset));
  cover property (system_reset_req);
  cover property (phy_loopback && phy_power_down);
endmodule // rst_ctl_checker

bind rx_and_phy_reset_control rst_ctl_checker #(.PHY_RESET_CYCLES(PHY_RESET_CYCLES)) props (
  .clk, .srst, .system_reset_req, .rx_packet_active, .rx_logic_reset, .rx_abort,
  .rx_enable, .phy_in_reset, .phy_loopback, .phy_power_down, .twisted_pair_enable
);

/* dv/host_model.sv */
// Purpose: host issuing avalon register cycles
// Assumes: one request at a time
// Notes: hung rises when no answer comes
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  output logic rd_done,
  output logic [31:0] rd_data,
  output logic hung
);
  // idle at time zero
  initial begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    rd_done = 1'b0;
    hung = 1'b0;
  end
  // one cycle, held until waitrequest is low
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    // waitrequest is looked at on the rising edge only
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    hung <= (avs_waitrequest !== 1'b0);
    rd_data <= avs_readdata;
    rd_done <= ~wr;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a; // released lines do not keep old value
    avs_writedata <= ~d;
    @(posedge clk);
    rd_done <= 1'b0;
  endtask
endmodule // host_model

/* dv/test_rx_and_phy_reset_control.sv */
// Purpose: bench for receive and phy reset control
// Assumes: reads checked from a queue of notes
// Notes: phy reset delay cut to 8 cycles
`timescale 1ns/1ps
module test_rx_and_phy_reset_control;
  localparam int unsigned P = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic system_reset_req = 1'b0;
  logic rx_packet_active = 1'b0;
  logic second_led_pin = 1'b1;
  logic avs_read, avs_write, avs_waitrequest, rd_done, hung;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd_data, v;
  logic rx_logic_reset, rx_abort, rx_enable, phy_in_reset, phy_loopback;
  logic twisted_pair_enable, phy_power_down, phy_full_duplex;
  logic [31:0] seed = 32'h7cb4;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [15:0] sel[4] = '{16'h4000, 16'h0800, 16'h0100, 16'h4900};
  int n_mismatch = 0;
  int n_tests = 0;
  int n;
  // 40 ns clock
  initial begin
    forever #20 clk = ~clk;
  end
  rx_and_phy_reset_control #(.PHY_RESET_CYCLES(P)) dut (
    .clk, .srst, .system_reset_req, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_packet_active, .second_led_pin,
    .rx_logic_reset, .rx_abort, .rx_enable, .phy_in_reset, .phy_loopback,
    .twisted_pair_enable, .phy_power_down, .phy_full_duplex
  );
  host_model host (
    .clk, .avs_readdata, .avs_waitrequest, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .rd_done, .rd_data, .hung
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask
  // note expected value, then read
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic chk(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t port", $time);
    end
  endtask
  // wait for the phy reset bit to clear
  task automatic poll();
    n = 0;
    do begin
      rd(4'h1, 32'h0, 32'h0);
      n++;
    end while (rd_data[15] !== 1'b0 && n < 30);
    chk(n < 30, 1'b1);
  endtask
  task automatic end_sim();
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("BAD %0t reads left unanswered", $time);
    end
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // compare each read with the oldest note
  always @(posedge clk) begin
    if (rd_done === 1'b1) begin
      n_tests++;
      if (exp_q.size() == 0 || (rd_data & msk_q[0]) !== (exp_q[0] & msk_q[0])) begin
        n_mismatch++;
        $display("BAD %0t rd %h", $time, rd_data);
      end
      if (exp_q.size() != 0) begin
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
    if (hung === 1'b1) begin
      n_mismatch++;
      $display("BAD %0t no answer", $time);
      end_sim();
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(4'h1, 32'h0100, 32'hffff_ffff);
    for (int i = 0; i < 4; i++) begin
      v = (rnd() & 32'h327f) | 32'(sel[i]);
      wr(4'h1, v);
      rd(4'h1, v & 32'h4900, 32'hffff_ffff);
      chk(twisted_pair_enable, !(v[14] | v[11]));
      chk(phy_loopback, v[14]);
      chk(phy_power_down, v[11]);
      chk(phy_full_duplex, v[8]);
    end
    wr(4'h1, 32'h8000);
    rd(4'h1, 32'h8100, 32'hc900);
    chk(phy_in_reset, 1'b1);
    poll();
    rd(4'h1, 32'h0100, 32'hffff_ffff);
    // receive-only reset with a packet in flight
    wr(4'h1, 32'h4000);
    rx_packet_active <= 1'b1;
    wr(4'h0, 32'h4);
    chk(rx_enable, 1'b1);
    wr(4'h0, 32'h44);
    chk(rx_logic_reset, 1'b1);
    rd(4'h0, 32'h40, 32'hffff_ffff);
    rd(4'h2, 32'h7, 32'h7);
    rd(4'h1, 32'h4000, 32'hffff_ffff);
    wr(4'h0, 32'h0);
    wr(4'h0, 32'h4);
    wr(4'h2, 32'h4);
    rd(4'h2, 32'h2, 32'h7);
    chk(rx_enable, 1'b1);
    // system reset pulse
    system_reset_req <= 1'b1;
    second_led_pin <= 1'b0;
    @(posedge clk);
    system_reset_req <= 1'b0;
    rd(4'h0, 32'h0, 32'hffff_ffff);
    poll();
    rd(4'h1, 32'h0000, 32'hffff_ffff);
    chk(phy_full_duplex, 1'b0);
    // unmapped place
    wr(4'h7, rnd());
    rd(4'h7, 32'h0, 32'hffff_ffff);
    @(posedge clk);
    end_sim();
  end
endmodule // test_rx_and_phy_reset_control
